// ---- dmie_pkg.sv ----
// Package for the miscellaneous instruction executor
package dmie_pkg;
  // Opcodes
  localparam logic [15:0] ZERO_TEST_OP = 16'hff58;
  localparam logic [15:0] VCALL_MASK = 16'hffe0;
  localparam logic [15:0] VCALL_OP = 16'h0020;
  localparam logic [15:0] BIT_TEST_AND_SET_HI_OP = 16'h560d;
  localparam logic [15:0] BRANCH_OP = 16'h5614;
  localparam logic [7:0] IOWR_OP = 8'hb0;
  localparam logic [3:0] BIT_TEST_AND_SET_LO_TOP = 4'h0;
  // Cycle counts
  localparam logic [3:0] VCALL_CYCLES = 4'h8;
  localparam logic [3:0] BRANCH_CYCLES = 4'h7;
  // Branch page and vector table
  localparam logic [5:0] BRANCH_PAGE = 6'h3f;
  localparam logic [21:0] VECTOR_BASE = 22'h3fffc0;
  // AHB-Lite offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SUM = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_IOOFS = 8'h10;
  localparam logic [7:0] OFS_RPT = 8'h14;
  // Status bit positions
  localparam int ST_TC = 0;
  localparam int ST_Z = 1;
  localparam int ST_N = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_IRQHOLD = 4;
  // Memory request carrier
  typedef struct packed {
    logic req;
    logic wr;
    logic wide;
    logic [21:0] addr;
    logic [31:0] wdata;
  } dmie_mem_req_type;
  // I/O write carrier
  typedef struct packed {
    logic strobe_n;
    logic [15:0] addr;
    logic [15:0] data;
  } dmie_io_type;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_VCALL = 5'b00010,
    ST_BRANCH = 5'b00100,
    ST_IOWR = 5'b01000,
    ST_FETCH = 5'b10000
  } dmie_state_type;
endpackage : dmie_pkg

// ---- dmie_core.sv ----
// Executor for zero test, vector call, bit set, I/O write, page branch
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module dmie_core #(
  parameter int SAVE_PAIRS = 1
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_reset, // Sync reset
  input wire logic i_instr_valid, // Instruction present
  input wire logic [31:0] i_instr, // Opcode word(s)
  input wire logic [15:0] i_bit_test_and_set_rdata, // Test-and-set read data
  input wire logic i_bit_test_and_set_is_sum_half, // Operand is lower sum word
  input wire logic [15:0] i_mem_rdata, // Fetched word for I/O write
  input wire logic [15:0] i_mult_high, // Multiplicand high reg
  input wire logic i_hw_irq_req, // Hardware interrupt request
  input wire logic i_haddr_sel, // AHB hsel
  input wire logic [31:0] i_haddr, // AHB haddr
  input wire logic [1:0] i_htrans, // AHB htrans
  input wire logic i_hwrite, // AHB hwrite
  input wire logic [2:0] i_hsize, // AHB hsize
  input wire logic [31:0] i_hwdata, // AHB hwdata
  input wire logic i_hready, // AHB hready
  output logic [31:0] o_hrdata, // AHB hrdata
  output logic o_hreadyout, // AHB hreadyout
  output logic o_hresp, // AHB hresp
  output dmie_pkg::dmie_mem_req_type o_mem, // Data memory request
  output dmie_pkg::dmie_io_type o_io, // I/O space pins
  output logic [21:0] o_program_counter, // Program counter
  output logic o_instr_ready, // Ready for next instruction
  output logic o_irq_hold // Hardware interrupts held off
);
  import dmie_pkg::*;

  initial begin
    if (SAVE_PAIRS < 1 || SAVE_PAIRS > 7) begin
      $error("SAVE_PAIRS must be 1..7");
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [31:0] main_sum_register;
  logic [15:0] status_word_zero;
  logic test_condition_flag;
  logic zero_flag;
  logic negative_flag;
  logic [15:0] repeat_countdown;
  logic [15:0] io_port_offset;
  logic [21:0] stack_pointer;
  logic [3:0] cycle_reg;
  logic [4:0] vector_index;
  dmie_state_type state_reg;
  logic bus_pend_reg;
  logic bus_wr_reg;
  logic [7:0] bus_addr_reg;

  // Decode helpers
  function automatic logic is_vcall(input logic [15:0] op);
    return (op & VCALL_MASK) == VCALL_OP;
  endfunction : is_vcall

  function automatic logic is_bit_test_and_set(input logic [31:0] w);
    return w[31:16] == BIT_TEST_AND_SET_HI_OP && w[15:12] == BIT_TEST_AND_SET_LO_TOP;
  endfunction : is_bit_test_and_set

  wire logic [15:0] op_hi = i_instr[31:16];
  wire logic take = i_instr_valid && state_reg == ST_IDLE;
  wire logic dec_zero = take && op_hi == ZERO_TEST_OP;
  wire logic dec_vcall = take && is_vcall(op_hi);
  wire logic dec_bit_test_and_set = take && is_bit_test_and_set(i_instr);
  wire logic dec_branch = take && op_hi == BRANCH_OP;
  wire logic dec_iowr = take && op_hi[15:8] == IOWR_OP;
  wire logic [3:0] bit_sel = i_instr[11:8];
  // Operand: lower sum word or the memory word read this cycle
  wire logic [15:0] bit_test_and_set_old = i_bit_test_and_set_is_sum_half ?
                               main_sum_register[15:0] : i_bit_test_and_set_rdata;
  wire logic [15:0] bit_test_and_set_new = bit_test_and_set_old | (16'h0001 << bit_sel);

  // ------------------------------------------------------------------
  // Bus write decode
  // ------------------------------------------------------------------
  wire logic bus_wr = bus_pend_reg && bus_wr_reg;
  wire logic wr_sum = bus_wr && bus_addr_reg == OFS_SUM;
  wire logic wr_rpt = bus_wr && bus_addr_reg == OFS_RPT;

  // Sequencer state
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      cycle_reg <= 4'h0;
      vector_index <= 5'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (dec_vcall) begin
            state_reg <= ST_VCALL;
            vector_index <= op_hi[4:0];
            cycle_reg <= VCALL_CYCLES - 4'h1;
          end else if (dec_branch) begin
            state_reg <= ST_BRANCH;
            cycle_reg <= BRANCH_CYCLES - 4'h1;
          end else if (dec_iowr) begin
            state_reg <= ST_FETCH;
          end
        end
        ST_VCALL, ST_BRANCH: begin
          if (cycle_reg == 4'h1) begin
            state_reg <= ST_IDLE;
          end
          cycle_reg <= cycle_reg - 4'h1;
        end
        ST_FETCH: state_reg <= ST_IOWR;
        ST_IOWR: begin
          if (repeat_countdown == 16'h0000) begin
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_FETCH;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Repeat countdown
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      repeat_countdown <= 16'h0000;
    end else if (wr_rpt) begin
      repeat_countdown <= i_hwdata[15:0];
    end else if (dec_zero || dec_vcall || dec_bit_test_and_set || dec_branch) begin
      repeat_countdown <= 16'h0000;
    end else if (state_reg == ST_IOWR && repeat_countdown != 16'h0000) begin
      repeat_countdown <= repeat_countdown - 16'h0001;
    end
  end

  // Sum register and flags
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      main_sum_register <= 32'h0000_0000;
      zero_flag <= 1'b0;
      negative_flag <= 1'b0;
      test_condition_flag <= 1'b0;
    end else begin
      if (wr_sum) begin
        main_sum_register <= i_hwdata;
      end else if (dec_bit_test_and_set && i_bit_test_and_set_is_sum_half) begin
        main_sum_register[15:0] <= bit_test_and_set_new;
      end
      if (dec_zero) begin
        negative_flag <= main_sum_register[31];
        zero_flag <= main_sum_register == 32'h0000_0000;
      end else if (dec_bit_test_and_set) begin
        test_condition_flag <= bit_test_and_set_old[bit_sel];
        if (i_bit_test_and_set_is_sum_half) begin
          negative_flag <= bit_test_and_set_new[15];
          zero_flag <= bit_test_and_set_new == 16'h0000;
        end
      end
    end
  end

  // Status word zero mirrors flags
  always_comb begin
    status_word_zero = 16'h0000;
    status_word_zero[ST_TC] = test_condition_flag;
    status_word_zero[ST_Z] = zero_flag;
    status_word_zero[ST_N] = negative_flag;
  end

  // Memory port: bit write-back and context save
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_mem <= '0;
      stack_pointer <= 22'h000000;
    end else begin
      o_mem.req <= 1'b0;
      if (dec_bit_test_and_set && !i_bit_test_and_set_is_sum_half) begin
        o_mem.req <= 1'b1;
        o_mem.wr <= 1'b1;
        o_mem.wide <= 1'b0;
        o_mem.wdata <= {16'h0000, bit_test_and_set_new};
      end else if (state_reg == ST_VCALL &&
                   cycle_reg > VCALL_CYCLES - 4'(SAVE_PAIRS) - 4'h1) begin
        // Pair saved low word at even address, single 32-bit write
        o_mem.req <= 1'b1;
        o_mem.wr <= 1'b1;
        o_mem.wide <= 1'b1;
        o_mem.addr <= {stack_pointer[21:1], 1'b0};
        o_mem.wdata <= {i_mult_high, status_word_zero};
        stack_pointer <= stack_pointer + 22'h000002;
      end else if (state_reg == ST_FETCH) begin
        o_mem.req <= 1'b1;
        o_mem.wr <= 1'b0;
        o_mem.wide <= 1'b0;
      end
    end
  end

  // Program counter
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_program_counter <= 22'h000000;
    end else if (state_reg == ST_BRANCH && cycle_reg == 4'h1) begin
      o_program_counter <= {BRANCH_PAGE, main_sum_register[15:0]};
    end else if (state_reg == ST_VCALL && cycle_reg == 4'h1) begin
      // Vector 0 jumps and saves context like any other vector, no reset state touched
      o_program_counter <= VECTOR_BASE + 22'({vector_index, 1'b0});
    end
  end

  // I/O space write; port offset steps up by one per strobe
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_io <= '{strobe_n: 1'b1, addr: 16'h0000, data: 16'h0000};
      io_port_offset <= 16'h0000;
    end else begin
      o_io.strobe_n <= 1'b1;
      if (dec_iowr) begin
        io_port_offset <= i_instr[15:0];
      end else if (state_reg == ST_IOWR) begin
        o_io.strobe_n <= 1'b0;
        o_io.addr <= io_port_offset;
        o_io.data <= i_mem_rdata;
        io_port_offset <= io_port_offset + 16'h0001;
      end
    end
  end

  // Interrupt hold-off and ready
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_irq_hold <= 1'b0;
      o_instr_ready <= 1'b0;
    end else begin
      o_irq_hold <= dec_vcall ||
                    (state_reg == ST_VCALL && cycle_reg != 4'h1);
      o_instr_ready <= state_reg == ST_IDLE && !dec_vcall &&
                       !dec_branch && !dec_iowr;
    end
  end

  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bus_pend_reg <= 1'b0;
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= 8'h00;
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      bus_pend_reg <= i_haddr_sel && i_htrans[1] && i_hready;
      bus_wr_reg <= i_hwrite;
      bus_addr_reg <= i_haddr[7:0];
      o_hreadyout <= 1'b1;
      if (i_haddr_sel && i_htrans[1] && i_hready && !i_hwrite) begin
        unique case (i_haddr[7:0])
          OFS_STATUS: o_hrdata <= {16'h0000, status_word_zero} |
                                  (32'(state_reg != ST_IDLE) << ST_BUSY) |
                                  (32'(o_irq_hold) << ST_IRQHOLD);
          OFS_SUM: o_hrdata <= main_sum_register;
          OFS_PC: o_hrdata <= {10'h000, o_program_counter};
          OFS_IOOFS: o_hrdata <= {16'h0000, io_port_offset};
          OFS_RPT: o_hrdata <= {16'h0000, repeat_countdown};
          default: o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_vcall_start;
    dec_vcall;
  endsequence

  sequence s_save_cycle;
    s_vcall_start ##1 state_reg == ST_VCALL;
  endsequence

  AST_ZERO_N: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    dec_zero && !wr_sum |=> negative_flag == $past(main_sum_register[31]))
    else $error("zero test negative flag wrong");
  AST_ZERO_Z: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    dec_zero && !wr_sum |=> zero_flag == ($past(main_sum_register) == 0))
    else $error("zero test zero flag wrong");
  AST_ZERO_KEEP: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    dec_zero && !wr_sum |=> $stable(main_sum_register))
    else $error("zero test altered sum");
  AST_NORPT: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (dec_zero || dec_vcall || dec_bit_test_and_set || dec_branch) && !wr_rpt |=>
    repeat_countdown == 16'h0000)
    else $error("countdown not cleared");
  AST_VCALL_LEN: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    s_vcall_start |=> (state_reg == ST_VCALL)[*7] ##1 state_reg == ST_IDLE)
    else $error("vector call length wrong");
  AST_HOLD: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    s_vcall_start |=> o_irq_hold[*7])
    else $error("interrupts not held");
  AST_HOLD_END: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    s_vcall_start |-> ##8 !o_irq_hold)
    else $error("interrupts held past the call");
  AST_SAVE: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    s_vcall_start |=> ##1 o_mem.req && o_mem.wide && !o_mem.addr[0])
    else $error("context save missing");
  AST_SAVE_WORD: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    s_save_cycle |=>
    o_mem.wdata == {$past(i_mult_high), $past(status_word_zero)})
    else $error("first saved pair wrong");
  AST_VCALL_PC: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    s_vcall_start |-> ##8 o_program_counter ==
    VECTOR_BASE + 22'({$past(op_hi[4:0], 8), 1'b0}))
    else $error("vector call target wrong");
  AST_BRANCH_PC: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    dec_branch && !wr_sum |-> ##7
    o_program_counter == {BRANCH_PAGE, $past(main_sum_register[15:0])})
    else $error("branch target wrong");
  AST_BIT_TEST_AND_SET_TC: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    dec_bit_test_and_set |=> test_condition_flag == ($past(i_bit_test_and_set_is_sum_half) ?
    $past(main_sum_register[bit_sel]) : $past(i_bit_test_and_set_rdata[bit_sel])))
    else $error("test flag wrong");
  AST_BIT_TEST_AND_SET_WB: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    dec_bit_test_and_set && !i_bit_test_and_set_is_sum_half |=> o_mem.req && o_mem.wr &&
    o_mem.wdata[15:0] == ($past(i_bit_test_and_set_rdata) |
    (16'h0001 << $past(bit_sel))))
    else $error("bit write-back wrong");
  AST_BIT_TEST_AND_SET_HALF: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    dec_bit_test_and_set && i_bit_test_and_set_is_sum_half && !wr_sum |=>
    main_sum_register[15:0] == ($past(main_sum_register[15:0]) |
    (16'h0001 << $past(bit_sel))) &&
    negative_flag == main_sum_register[15] &&
    zero_flag == (main_sum_register[15:0] == 16'h0000))
    else $error("sum half test-and-set wrong");
  AST_IO_INC: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    state_reg == ST_IOWR |=> io_port_offset == $past(io_port_offset) + 16'h0001)
    else $error("port offset not incremented");
  AST_IO_STROBE: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    state_reg == ST_IOWR |=> !o_io.strobe_n &&
    o_io.addr == $past(io_port_offset) && o_io.data == $past(i_mem_rdata))
    else $error("I/O strobe, address or data wrong");
  AST_IO_DONE: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    state_reg == ST_IOWR && repeat_countdown == 16'h0000 |=>
    state_reg == ST_IDLE)
    else $error("I/O write ran past its count");
endmodule : dmie_core

// ---- dmie_mem_model.sv ----
// Far-side model of data memory, stack and I/O space
`timescale 1ns/1ps
module dmie_mem_model (
  input wire logic i_core_clk, // Core clock
  input wire dmie_pkg::dmie_mem_req_type i_mem, // Memory request
  input wire dmie_pkg::dmie_io_type i_io, // I/O space pins
  output logic [15:0] o_rdata // Fetched word
);
  import dmie_pkg::*;
  logic [15:0] served = 16'hffff;
  dmie_mem_req_type last_wr = '0;
  logic [15:0] io_addr_q[$];
  logic [15:0] io_data_q[$];

  // ----------------------------------------
  // Read answer and released bus
  // ----------------------------------------
  // Data answers within the read cycle; an idle bus shows its inverse
  assign o_rdata = (i_mem.req && !i_mem.wr) ? ~i_mem.addr[15:0] : ~served;
  always @(posedge i_core_clk) begin
    if (i_mem.req && !i_mem.wr) begin
      served <= ~i_mem.addr[15:0];
    end
  end

  // ----------------------------------------
  // Write capture
  // ----------------------------------------
  // Keep the last memory write and every I/O strobe
  always @(posedge i_core_clk) begin
    if (i_mem.req && i_mem.wr) begin
      last_wr <= i_mem;
    end
    if (i_io.strobe_n === 1'b0) begin
      io_addr_q.push_back(i_io.addr);
      io_data_q.push_back(i_io.data);
    end
  end
endmodule : dmie_mem_model

// ---- tb_top.sv ----
// Testbench for the miscellaneous instruction executor
`timescale 1ns/1ps
module tb_top;
  import dmie_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_instr_valid = 1'b0;
  logic [31:0] i_instr = 32'h0;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [15:0] i_bit_test_and_set_rdata = 16'h0;
  logic [15:0] i_mult_high = 16'hbee0;
  logic [15:0] i_mem_rdata;
  logic i_bit_test_and_set_is_sum_half = 1'b0;
  logic i_hw_irq_req = 1'b1;
  logic i_haddr_sel = 1'b0;
  logic i_hwrite = 1'b0;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] o_hrdata;
  logic o_hreadyout, o_hresp, o_instr_ready, o_irq_hold;
  dmie_mem_req_type o_mem;
  dmie_io_type o_io;
  logic [21:0] o_program_counter;
  logic [31:0] rd;
  logic [15:0] exp16;
  logic [21:0] exp22;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n, holds;
  logic [31:0] zt[3] = '{32'h8000_0000, 32'h0, 32'h1};
  logic [3:0] tbit[3] = '{4'h0, 4'h7, 4'hf};
  logic thalf[3] = '{1'b1, 1'b0, 1'b1};
  logic [4:0] vec[3] = '{5'h00, 5'h0d, 5'h1f};

  dmie_core DUT (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_bit_test_and_set_rdata(i_bit_test_and_set_rdata), .i_bit_test_and_set_is_sum_half(i_bit_test_and_set_is_sum_half),
    .i_mem_rdata(i_mem_rdata), .i_mult_high(i_mult_high),
    .i_hw_irq_req(i_hw_irq_req), .i_haddr_sel(i_haddr_sel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_mem(o_mem), .o_io(o_io), .o_program_counter(o_program_counter),
    .o_instr_ready(o_instr_ready), .o_irq_hold(o_irq_hold));
  dmie_mem_model PARTNER (.i_core_clk(i_core_clk), .i_mem(o_mem),
    .i_io(o_io), .o_rdata(i_mem_rdata));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial forever #4 i_core_clk = ~i_core_clk;
  // Cut a hang short well beyond the expected run length
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One AHB single word transfer; ready and data taken at rising edges
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    i_haddr_sel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= wr;
    @(posedge i_core_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
    i_haddr_sel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    @(posedge i_core_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
    rd = o_hrdata;
  endtask : ahb

  // Issue one instruction, then watch the program counter and hold-off
  task automatic exec(input logic [31:0] ins, input logic [21:0] pc_exp);
    logic rdy;
    i_instr_valid <= 1'b1;
    i_instr <= ins;
    do begin
      @(negedge i_core_clk);
      rdy = o_instr_ready;
      @(posedge i_core_clk);
    end while (rdy !== 1'b1);
    i_instr_valid <= 1'b0;
    n = 0;
    holds = 0;
    for (int k = 1; k <= 14; k++) begin
      @(negedge i_core_clk);
      if (o_irq_hold === 1'b1) holds++;
      if (n == 0 && o_program_counter === pc_exp) n = k;
      @(posedge i_core_clk);
    end
  endtask : exec

  task automatic print_verdict();
    $display("Mismatches %0d of %0d comparisons", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    // Reset values and an unmapped place
    ahb(1'b0, OFS_PC, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // Zero test on negative, zero and small positive sums
    foreach (zt[i]) begin
      ahb(1'b1, OFS_SUM, zt[i]);
      ahb(1'b1, OFS_RPT, 32'h5);
      exec({ZERO_TEST_OP, 16'h0}, o_program_counter);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[ST_N], zt[i][31]);
      chk(rd[ST_Z], zt[i] == 32'h0);
      ahb(1'b0, OFS_SUM, 32'h0);
      chk(rd, zt[i]);
      ahb(1'b0, OFS_RPT, 32'h0);
      chk(rd, 32'h0);
    end
    // Bit test-and-set at both ends and the middle of the word
    foreach (tbit[i]) begin
      i_bit_test_and_set_rdata <= 16'h0080;
      i_bit_test_and_set_is_sum_half <= thalf[i];
      ahb(1'b1, OFS_SUM, 32'h0000_0080);
      ahb(1'b1, OFS_RPT, 32'h3);
      exp16 = 16'h0080 | (16'h1 << tbit[i]);
      exec({BIT_TEST_AND_SET_HI_OP, BIT_TEST_AND_SET_LO_TOP, tbit[i], 8'h00}, o_program_counter);
      if (!thalf[i]) chk(PARTNER.last_wr.wdata[15:0], exp16);
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[ST_TC], tbit[i] == 4'h7);
      if (thalf[i]) chk(rd[ST_N], exp16[15]);
      if (thalf[i]) chk(rd[ST_Z], 1'b0);
      ahb(1'b0, OFS_SUM, 32'h0);
      if (thalf[i]) chk(rd, {16'h0, exp16});
      ahb(1'b0, OFS_RPT, 32'h0);
      chk(rd, 32'h0);
    end
    // Repeated I/O write wrapping past the top of the port range
    PARTNER.io_addr_q.delete();
    PARTNER.io_data_q.delete();
    ahb(1'b1, OFS_RPT, 32'h2);
    exec({IOWR_OP, 8'h00, 16'hfffe}, o_program_counter);
    chk(PARTNER.io_addr_q.size(), 32'h3);
    foreach (PARTNER.io_addr_q[i]) begin
      exp16 = 16'hfffe + i[15:0];
      chk(PARTNER.io_addr_q[i], exp16);
      chk(PARTNER.io_data_q[i], PARTNER.served);
    end
    chk(o_io.strobe_n, 1'b1);
    // Vector calls with a hardware request pending, vectors 1-12 avoided
    ahb(1'b1, OFS_SUM, 32'h1234_abcd);
    foreach (vec[i]) begin
      i_mult_high <= 16'hbee0 + {11'h0, vec[i]};
      ahb(1'b1, OFS_RPT, 32'h4);
      exp22 = VECTOR_BASE + {16'h0, vec[i], 1'b0};
      exec({VCALL_OP | {11'h0, vec[i]}, 16'h0}, exp22);
      chk(n, VCALL_CYCLES);
      chk(o_program_counter, exp22);
      chk(holds, VCALL_CYCLES - 4'h1);
      chk(PARTNER.last_wr.wide, 1'b1);
      chk(PARTNER.last_wr.addr[0], 1'b0);
      chk(PARTNER.last_wr.wdata[31:16], i_mult_high);
      chk(PARTNER.last_wr.wdata[15:0], 16'h1 << ST_N);
      ahb(1'b0, OFS_SUM, 32'h0);
      chk(rd, 32'h1234_abcd);
      ahb(1'b0, OFS_RPT, 32'h0);
      chk(rd, 32'h0);
    end
    // Page branch through the lower sum word
    ahb(1'b1, OFS_RPT, 32'h1);
    exec({BRANCH_OP, 16'h0}, {BRANCH_PAGE, 16'habcd});
    chk(n, BRANCH_CYCLES);
    chk(o_program_counter, {BRANCH_PAGE, 16'habcd});
    ahb(1'b0, OFS_RPT, 32'h0);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule : tb_top
